// [pkg/psl_map.svh]
// Address map, field positions and reset values of the status bank
// Contract
// - Entry through the reset vector sets the NMI entry flag to 1 for an NMI and 0 otherwise.
// - Writing 0 clears the NMI entry flag; writing 1 leaves it unchanged.
// - Bit 18 always reads zero and software writes zero to it.
// - Bits 17:16, 7:5 and 3 ignore writes and read zero.
// - An interrupt is taken only when enabled and both its mask and pending bits are set.
// - The user mode bit selects user mode at 1, kernel at 0, and is read/write.
// - Exception level or error level forces kernel mode without touching the user mode bit.
// - Reset, soft reset and NMI set the error level bit, reset value 1; it forces kernel mode.
// - With error level set, exception return uses the error return address.
// - With error level set, the low user segment is unmapped and uncached; the code drives only kuseg_unmapped and has no cache control output.
// - Any other exception sets the exception level bit; it forces kernel mode.
// - With a translation buffer and exception level set, refills use the general vector.
// - With exception level set, a further exception leaves the exception return address.
// - The master enable gates all software and hardware interrupts.
// - Interrupts are enabled only with master enable 1 and both levels and debug mode 0.
`ifndef PSL_MAP_SVH
`define PSL_MAP_SVH
`define PSL_ADDR_W 12
`define PSL_OFF_STATUS 12'h000
`define PSL_OFF_EPC 12'h004
`define PSL_OFF_ERRPC 12'h008
`define PSL_BIT_NMI 19
`define PSL_BIT_UM 4
`define PSL_BIT_ERL 2
`define PSL_BIT_EXL 1
`define PSL_BIT_IE 0
`define PSL_BIT_ZERO 18
`define PSL_RSVD_HI_MSB 17
`define PSL_RSVD_HI_LSB 16
`define PSL_RSVD_MID_MSB 7
`define PSL_RSVD_MID_LSB 5
`define PSL_BIT_RSVD 3
`define PSL_IM_HI 15
`define PSL_IM_LO 8
`define PSL_RST_NMI 1'h0
`define PSL_RST_ERL 1'h1
`define PSL_RST_EXL 1'h0
`define PSL_RST_UM 1'h0
`define PSL_RST_IE 1'h0
`define PSL_RST_IM 8'h00
`define PSL_RST_PC 32'h0000_0000
`endif

// [pkg/psl_pkg.sv]
// Types shared by the status bank modules
`default_nettype none
package psl_pkg;
    typedef enum logic [1:0] {
        PSL_EXC_OTHER = 2'b00,
        PSL_EXC_SOFT = 2'b01,
        PSL_EXC_NMI = 2'b10
    } psl_exc_kind_t;
    typedef enum logic [1:0] {
        PSL_SEL_STATUS = 2'b00,
        PSL_SEL_EPC = 2'b01,
        PSL_SEL_ERRPC = 2'b10,
        PSL_SEL_NONE = 2'b11
    } psl_sel_t;
endpackage : psl_pkg
`default_nettype wire

// [pkg/psl_if.sv]
// Internal carrier between the status bank and its helpers
`default_nettype none
interface psl_if;
    import psl_pkg::*;
    logic [7:0] im;
    logic um, error_level_bit, exception_level_bit, ie, debug_mode;
    logic [7:0] pending;
    logic kernel, int_en;
    logic [7:0] int_take;
    logic setup, wr_fire;
    psl_sel_t sel;
    modport core (
        output im, um, error_level_bit, exception_level_bit, ie, debug_mode, pending,
        input kernel, int_en, int_take, setup, wr_fire, sel
    );
    modport mode (
        input im, um, error_level_bit, exception_level_bit, ie, debug_mode, pending,
        output kernel, int_en, int_take
    );
    modport bus (output setup, wr_fire, sel);
endinterface : psl_if
`default_nettype wire

// [core/psl_apb_decode.sv]
// APB phase and address decode for the status bank
`include "psl_map.svh"
`default_nettype none
module psl_apb_decode (
    // Bus request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PSL_ADDR_W-1:0] paddr,
    input wire logic pready,
    // Decoded request
    psl_if.bus dec
);
    import psl_pkg::*;
    always_comb begin
        dec.setup = psel && !penable;
        dec.wr_fire = psel && penable && pready && pwrite;
        case (paddr)
            `PSL_OFF_STATUS: dec.sel = PSL_SEL_STATUS;
            `PSL_OFF_EPC: dec.sel = PSL_SEL_EPC;
            `PSL_OFF_ERRPC: dec.sel = PSL_SEL_ERRPC;
            default: dec.sel = PSL_SEL_NONE;
        endcase
    end
endmodule : psl_apb_decode
`default_nettype wire

// [core/psl_mode_logic.sv]
// Mode and interrupt gating from the status fields
`default_nettype none
module psl_mode_logic (
    // Status fields in, mode and interrupt decisions out
    psl_if.mode st
);
    import psl_pkg::*;
    // Debug mode is its own mode, so it only affects the interrupt gate here
    assign st.kernel = !st.um || st.exception_level_bit || st.error_level_bit;
    assign st.int_en = st.ie && !st.exception_level_bit && !st.error_level_bit && !st.debug_mode;
    for (genvar i = 0; i < 8; i++) begin : g_line
        assign st.int_take[i] = st.int_en && st.im[i] && st.pending[i];
    end
endmodule : psl_mode_logic
`default_nettype wire

// [core/psl_status.sv]
// Low half of the privileged status register with its exception side effects
//
// Our own choices: the placing of the registers and the APB register port.
`include "psl_map.svh"
`default_nettype none
module psl_status (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PSL_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Exception entry
    input wire logic exc_take,
    input wire psl_pkg::psl_exc_kind_t exc_kind,
    input wire logic [31:0] exc_pc,
    // Exception return
    input wire logic exception_return_instruction_req,
    output logic exception_return_instruction_valid,
    output logic [31:0] exception_return_instruction_target,
    // Core context
    input wire logic [7:0] pending_in,
    input wire logic debug_mode,
    input wire logic tlb_present,
    // Mode and interrupt decisions
    output logic kernel_mode,
    output logic int_enabled,
    output logic [7:0] int_take,
    output logic int_request,
    output logic kuseg_unmapped,
    output logic refill_to_general
);
    import psl_pkg::*;

    psl_if st ();

    logic nmi_flag;
    logic [7:0] im;
    logic um;
    logic error_level_bit;
    logic exception_level_bit;
    logic ie;
    logic [31:0] exception_return_pc;
    logic [31:0] errpc;
    logic entry_reset;
    logic entry_other;
    logic exception_return_instruction_go;
    logic wr_status;
    logic wr_epc;
    logic wr_errpc;
    logic [31:0] status_word;
    logic [31:0] next_rdata;
    logic int_en_ok;

    psl_apb_decode u_dec (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pready(pready),
        .dec(st)
    );

    psl_mode_logic u_mode (
        .st(st)
    );

    assign st.im = im;
    assign st.um = um;
    assign st.error_level_bit = error_level_bit;
    assign st.exception_level_bit = exception_level_bit;
    assign st.ie = ie;
    assign st.debug_mode = debug_mode;
    assign st.pending = pending_in;
    assign int_en_ok = ie && !exception_level_bit && !error_level_bit && !debug_mode;

    // Kind code 2'b11 is not an entry at all; it is dropped rather than guessed
    assign entry_reset = exc_take && (exc_kind == PSL_EXC_SOFT || exc_kind == PSL_EXC_NMI);
    assign entry_other = exc_take && exc_kind == PSL_EXC_OTHER;
    // An exception in the same cycle as a return wins; the return is lost
    assign exception_return_instruction_go = exception_return_instruction_req && !exc_take;
    assign wr_status = st.wr_fire && st.sel == PSL_SEL_STATUS;
    assign wr_epc = st.wr_fire && st.sel == PSL_SEL_EPC;
    assign wr_errpc = st.wr_fire && st.sel == PSL_SEL_ERRPC;

    // Entry flag
    always_ff @(posedge core_clk) begin
        if (rst) begin
            nmi_flag <= `PSL_RST_NMI;
        end else if (entry_reset) begin
            nmi_flag <= (exc_kind == PSL_EXC_NMI);
        end else if (wr_status && !pwdata[`PSL_BIT_NMI]) begin
            nmi_flag <= 1'b0;
        end
    end

    // Error level
    always_ff @(posedge core_clk) begin
        if (rst) begin
            error_level_bit <= `PSL_RST_ERL;
        end else if (entry_reset) begin
            error_level_bit <= 1'b1;
        end else if (entry_other) begin
            error_level_bit <= error_level_bit;
        end else if (exception_return_instruction_go && error_level_bit) begin
            error_level_bit <= 1'b0;
        end else if (wr_status) begin
            error_level_bit <= pwdata[`PSL_BIT_ERL];
        end
    end

    // Exception level
    always_ff @(posedge core_clk) begin
        if (rst) begin
            exception_level_bit <= `PSL_RST_EXL;
        end else if (entry_other) begin
            exception_level_bit <= 1'b1;
        end else if (entry_reset) begin
            exception_level_bit <= exception_level_bit;
        end else if (exception_return_instruction_go && !error_level_bit) begin
            exception_level_bit <= 1'b0;
        end else if (wr_status) begin
            exception_level_bit <= pwdata[`PSL_BIT_EXL];
        end
    end

    // Mask, user mode and master enable, software owned
    always_ff @(posedge core_clk) begin
        if (rst) begin
            im <= `PSL_RST_IM;
            um <= `PSL_RST_UM;
            ie <= `PSL_RST_IE;
        end else if (wr_status) begin
            im <= pwdata[`PSL_IM_HI:`PSL_IM_LO];
            um <= pwdata[`PSL_BIT_UM];
            ie <= pwdata[`PSL_BIT_IE];
        end
    end

    // Exception return address
    always_ff @(posedge core_clk) begin
        if (rst) begin
            exception_return_pc <= `PSL_RST_PC;
        end else if (entry_other && !exception_level_bit) begin
            exception_return_pc <= exc_pc;
        end else if (wr_epc && !exc_take) begin
            exception_return_pc <= pwdata;
        end
    end

    // Error return address
    always_ff @(posedge core_clk) begin
        if (rst) begin
            errpc <= `PSL_RST_PC;
        end else if (entry_reset) begin
            errpc <= exc_pc;
        end else if (wr_errpc && !exc_take) begin
            errpc <= pwdata;
        end
    end

    // Return target
    always_ff @(posedge core_clk) begin
        if (rst) begin
            exception_return_instruction_valid <= 1'b0;
            exception_return_instruction_target <= `PSL_RST_PC;
        end else begin
            exception_return_instruction_valid <= exception_return_instruction_go;
            if (exception_return_instruction_go) begin
                exception_return_instruction_target <= error_level_bit ? errpc : exception_return_pc;
            end
        end
    end

    // Mode and interrupt outputs, one cycle behind the fields
    always_ff @(posedge core_clk) begin
        if (rst) begin
            kernel_mode <= `PSL_RST_ERL;
            int_enabled <= 1'b0;
            int_take <= 8'h00;
            int_request <= 1'b0;
        end else begin
            kernel_mode <= st.kernel;
            int_enabled <= st.int_en;
            int_take <= st.int_take;
            int_request <= |st.int_take;
        end
    end

    // Address space and vector steering
    always_ff @(posedge core_clk) begin
        if (rst) begin
            kuseg_unmapped <= `PSL_RST_ERL;
            refill_to_general <= 1'b0;
        end else begin
            kuseg_unmapped <= error_level_bit;
            refill_to_general <= tlb_present && exception_level_bit;
        end
    end

    // Read image; unlisted bits stay zero
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`PSL_BIT_NMI] = nmi_flag;
        status_word[`PSL_IM_HI:`PSL_IM_LO] = im;
        status_word[`PSL_BIT_UM] = um;
        status_word[`PSL_BIT_ERL] = error_level_bit;
        status_word[`PSL_BIT_EXL] = exception_level_bit;
        status_word[`PSL_BIT_IE] = ie;
        case (st.sel)
            PSL_SEL_STATUS: next_rdata = status_word;
            PSL_SEL_EPC: next_rdata = exception_return_pc;
            PSL_SEL_ERRPC: next_rdata = errpc;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data is caught in the setup cycle so that prdata comes from a flop
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (st.setup) begin
                prdata <= next_rdata;
                pslverr <= (st.sel == PSL_SEL_NONE);
            end
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    a_nmi_no_set: assert property (
        $rose(nmi_flag) |-> $past(exc_take && exc_kind == PSL_EXC_NMI)
    ) else $error("entry flag rose without an NMI entry");

    a_nmi_clear_wr: assert property (
        (wr_status && !pwdata[`PSL_BIT_NMI] && !exc_take) |=> !nmi_flag
    ) else $error("writing zero did not clear the entry flag");

    a_reset_entry: assert property (
        entry_reset |=> error_level_bit && (nmi_flag == $past(exc_kind == PSL_EXC_NMI))
    ) else $error("reset class entry left wrong error level or entry flag");

    a_rsvd_read_zero: assert property (
        (psel && penable && pready && st.sel == PSL_SEL_STATUS)
            |-> (prdata[`PSL_RSVD_HI_MSB:`PSL_RSVD_HI_LSB] == 2'h0
                && prdata[`PSL_RSVD_MID_MSB:`PSL_RSVD_MID_LSB] == 3'h0
                && !prdata[`PSL_BIT_RSVD])
    ) else $error("reserved status bits read nonzero");

    a_zero_bit_read: assert property (
        (psel && penable && pready && st.sel == PSL_SEL_STATUS) |-> !prdata[`PSL_BIT_ZERO]
    ) else $error("always-zero status bit read nonzero");

    a_kernel_forced: assert property (
        (exception_level_bit || error_level_bit) |=> kernel_mode
    ) else $error("level bit set but not in kernel mode");

    a_um_kept: assert property (
        (exc_take && !wr_status) |=> um == $past(um)
    ) else $error("exception entry altered the user mode bit");

    a_exl_entry: assert property (
        entry_other |=> exception_level_bit ##1 (kernel_mode && !int_enabled)
    ) else $error("ordinary entry did not raise exception level");

    a_epc_hold: assert property (
        (entry_other && exception_level_bit) |=> $stable(exception_return_pc)
    ) else $error("return address changed under exception level");

    a_exception_return_instruction_source: assert property (
        (exception_return_instruction_go && error_level_bit) |=> exception_return_instruction_valid && exception_return_instruction_target == $past(errpc)
    ) else $error("return under error level used wrong address");

    a_int_gate: assert property (
        int_request |-> $past(ie && !exception_level_bit && !error_level_bit && !debug_mode)
    ) else $error("interrupt raised while interrupts disabled");

    a_int_line: assert property (
        (int_en_ok && im[0] && pending_in[0]) |=> int_take[0]
    ) else $error("enabled pending line 0 not taken");

    a_erl_disables: assert property (
        error_level_bit |=> !int_enabled && kernel_mode && kuseg_unmapped
    ) else $error("error level did not force kernel with interrupts off");

    a_refill_vec: assert property (
        (tlb_present && exception_level_bit) |=> refill_to_general
    ) else $error("refill not steered to the general vector");

    a_nmi_keep_one: assert property (
        (wr_status && pwdata[`PSL_BIT_NMI] && !entry_reset) |=> nmi_flag == $past(nmi_flag)
    ) else $error("writing one changed the entry flag");

    a_um_write: assert property (
        wr_status |=> um == $past(pwdata[`PSL_BIT_UM])
    ) else $error("user mode bit did not take the written value");

    a_user_mode_out: assert property (
        (um && !exception_level_bit && !error_level_bit) |=> !kernel_mode
    ) else $error("user mode selected but kernel mode shown");

    a_um_exception_return_instruction_kept: assert property (
        (exception_return_instruction_go && !wr_status) |=> um == $past(um)
    ) else $error("exception return altered the user mode bit");

    a_exception_return_instruction_epc_src: assert property (
        (exception_return_instruction_go && !error_level_bit) |=> exception_return_instruction_valid && exception_return_instruction_target == $past(exception_return_pc)
    ) else $error("return without error level used wrong address");

    a_kuseg_mapped: assert property (
        !error_level_bit |=> !kuseg_unmapped
    ) else $error("low user segment unmapped without error level");

    a_exl_disables: assert property (
        exception_level_bit |=> !int_enabled && kernel_mode
    ) else $error("exception level did not force kernel with interrupts off");

    a_refill_off: assert property (
        !(tlb_present && exception_level_bit) |=> !refill_to_general
    ) else $error("refill steered to the general vector without cause");

    a_epc_load: assert property (
        (entry_other && !exception_level_bit) |=> exception_return_pc == $past(exc_pc)
    ) else $error("first entry did not load the return address");

    a_ie_gates: assert property (
        !ie |=> !int_enabled && !int_request
    ) else $error("interrupt seen with the master enable off");

    a_int_enable: assert property (
        int_en_ok |=> int_enabled
    ) else $error("interrupts not enabled although every condition holds");

    a_mask_blocks: assert property (
        !(|im) |=> !int_request
    ) else $error("interrupt taken with every mask bit clear");

endmodule : psl_status
`default_nettype wire

// [sim/tb_processor_status_low_fields.sv]
// Self-checking bench for the low half of the privileged status register
`include "psl_map.svh"
`default_nettype none
module tb_processor_status_low_fields;
    timeunit 1ns;
    timeprecision 1ns;
    import psl_pkg::*;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic exc_take = 1'b0;
    psl_exc_kind_t exc_kind = PSL_EXC_OTHER;
    logic [31:0] exc_pc = 32'h0000_0000;
    logic exception_return_instruction_req = 1'b0;
    logic exception_return_instruction_valid;
    logic [31:0] exception_return_instruction_target;
    logic [7:0] pending_in = 8'h05;
    logic debug_mode = 1'b0;
    logic tlb_present = 1'b1;
    logic kernel_mode;
    logic int_enabled;
    logic [7:0] int_take;
    logic int_request;
    logic kuseg_unmapped;
    logic refill_to_general;
    logic [31:0] rd_data;
    logic rd_err;
    int n_mismatch = 0;
    int checked = 0;

    psl_status dut_u (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .exc_take(exc_take), .exc_kind(exc_kind), .exc_pc(exc_pc), .exception_return_instruction_req(exception_return_instruction_req),
        .exception_return_instruction_valid(exception_return_instruction_valid), .exception_return_instruction_target(exception_return_instruction_target), .pending_in(pending_in),
        .debug_mode(debug_mode), .tlb_present(tlb_present), .kernel_mode(kernel_mode),
        .int_enabled(int_enabled), .int_take(int_take), .int_request(int_request),
        .kuseg_unmapped(kuseg_unmapped), .refill_to_general(refill_to_general)
    );

    always #25 core_clk = ~core_clk;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    // One APB transfer; waits on pready rather than assuming zero wait states
    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge core_clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees pready
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : apb

    // Only bits 19:0 belong to this block, so upper bits are not judged
    task automatic rd_status(input logic [31:0] exp);
        apb(1'b0, `PSL_OFF_STATUS, 32'h0000_0000);
        chk(rd_data & 32'h000f_ffff, exp);
    endtask : rd_status

    task automatic exc(input psl_exc_kind_t k, input logic [31:0] pc);
        @(posedge core_clk);
        exc_take <= 1'b1;
        exc_kind <= k;
        exc_pc <= pc;
        @(posedge core_clk);
        exc_take <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : exc

    task automatic exception_return_instruction(input logic [31:0] exp);
        @(posedge core_clk);
        exception_return_instruction_req <= 1'b1;
        @(posedge core_clk);
        exception_return_instruction_req <= 1'b0;
        #1;
        chk({31'h0, exception_return_instruction_valid}, 32'h1);
        chk(exception_return_instruction_target, exp);
        repeat (3) @(posedge core_clk);
    endtask : exception_return_instruction

    task automatic t_reset_and_fields;
        rd_status(32'h0000_0004);
        chk({31'h0, kernel_mode}, 32'h1);
        chk({31'h0, kuseg_unmapped}, 32'h1);
        apb(1'b1, `PSL_OFF_STATUS, 32'h000b_ffff);
        rd_status(32'h0000_ff17);
        chk(rd_data & 32'h000c_0000, 32'h0);
        chk({31'h0, kernel_mode}, 32'h1);
        chk({31'h0, int_enabled}, 32'h0);
        chk({31'h0, refill_to_general}, 32'h1);
    endtask : t_reset_and_fields

    task automatic t_user_and_interrupts;
        apb(1'b1, `PSL_OFF_STATUS, 32'h0000_ff11);
        chk({31'h0, kernel_mode}, 32'h0);
        chk({31'h0, kuseg_unmapped}, 32'h0);
        chk({31'h0, refill_to_general}, 32'h0);
        chk({31'h0, int_enabled}, 32'h1);
        chk({24'h0, int_take}, 32'h0000_0005);
        chk({31'h0, int_request}, 32'h1);
        apb(1'b1, `PSL_OFF_STATUS, 32'h0000_0111);
        chk({24'h0, int_take}, 32'h0000_0001);
        apb(1'b1, `PSL_OFF_STATUS, 32'h0000_ff10);
        chk({24'h0, int_take}, 32'h0);
        apb(1'b1, `PSL_OFF_STATUS, 32'h0000_ff11);
        debug_mode <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk({31'h0, int_enabled}, 32'h0);
        chk({31'h0, int_request}, 32'h0);
        debug_mode <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask : t_user_and_interrupts

    task automatic t_exceptions;
        exc(PSL_EXC_OTHER, 32'h0000_0100);
        rd_status(32'h0000_ff13);
        chk({31'h0, kernel_mode}, 32'h1);
        chk({31'h0, int_enabled}, 32'h0);
        exc(PSL_EXC_OTHER, 32'h0000_0200);
        apb(1'b0, `PSL_OFF_EPC, 32'h0);
        chk(rd_data, 32'h0000_0100);
        exception_return_instruction(32'h0000_0100);
        rd_status(32'h0000_ff11);
    endtask : t_exceptions

    task automatic t_nmi_and_soft;
        exc(PSL_EXC_NMI, 32'h0000_0300);
        rd_status(32'h0008_ff15);
        chk({31'h0, kuseg_unmapped}, 32'h1);
        exception_return_instruction(32'h0000_0300);
        rd_status(32'h0008_ff11);
        apb(1'b1, `PSL_OFF_STATUS, 32'h0000_ff11);
        rd_status(32'h0000_ff11);
        exc(PSL_EXC_SOFT, 32'h0000_0400);
        rd_status(32'h0000_ff15);
        exc(psl_exc_kind_t'(2'b11), 32'h0000_0500);
        rd_status(32'h0000_ff15);
        apb(1'b0, `PSL_OFF_ERRPC, 32'h0);
        chk(rd_data, 32'h0000_0400);
        apb(1'b0, 12'h00c, 32'h0);
        chk({31'h0, rd_err}, 32'h1);
    endtask : t_nmi_and_soft

    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        t_reset_and_fields();
        t_user_and_interrupts();
        t_exceptions();
        t_nmi_and_soft();
        report_and_stop();
    end

    // Whole run is under two hundred cycles; this limit catches a hung handshake
    initial begin
        repeat (5000) @(posedge core_clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule : tb_processor_status_low_fields
`default_nettype wire
